// file: src/lpmpc_consts.svh
// Constants for the low power mode and pad control block
`ifndef LPMPC_CONSTS_SVH
`define LPMPC_CONSTS_SVH
`define LPMPC_NPINS 16
`define LPMPC_NIFS 2
`define LPMPC_PLL_LOCK_NS 1000
`define LPMPC_CLK_PERIOD_NS 4
`define LPMPC_PLL_LOCK_CYC ((`LPMPC_PLL_LOCK_NS + `LPMPC_CLK_PERIOD_NS - 1) / `LPMPC_CLK_PERIOD_NS)
`define LPMPC_CNT_W 10
`define LPMPC_CTL15_IDX 15
`define LPMPC_PULL_HIZ 2'h0
`define LPMPC_PULL_UP 2'h1
`define LPMPC_PULL_DOWN 2'h2
`define LPMPC_PULL_HOLD 2'h3
`define LPMPC_DRV_FULL 2'h3
`define LPMPC_REQ_NONE 2'h0
`define LPMPC_REQ_PHYON 2'h1
`define LPMPC_REQ_PHYOFF 2'h2
`define LPMPC_REQ_STBY 2'h3
`endif

// file: src/lpmpc_pkg.sv
// Types for the low power mode and pad control block
package lpmpc_pkg;
    typedef enum logic [2:0] {
        LPMPC_RUN = 3'h0,
        LPMPC_PHYON = 3'h1,
        LPMPC_PHYOFF = 3'h3,
        LPMPC_STBY = 3'h2,
        LPMPC_LOCK = 3'h6
    } lpmpc_state_e;
    typedef logic [1:0] lpmpc_req_t;
endpackage

// file: src/lpmpc_if.sv
// Interface between the sequencer and the host processor
`timescale 1ns/1ps
`default_nettype none
interface lpmpc_if;
    logic req_valid;
    logic [1:0] req_mode;
    logic req_ack;
    logic idle;
    logic [2:0] state;
    logic woke_reset_pc;
    modport dev (input req_valid, input req_mode, output req_ack, output idle,
        output state, output woke_reset_pc);
    modport host (output req_valid, output req_mode, input req_ack, input idle,
        input state, input woke_reset_pc);
endinterface
`default_nettype wire

// file: src/lpmpc_host.sv
// Host end: mailbox and power register writer
`timescale 1ns/1ps
`default_nettype none
`include "lpmpc_consts.svh"
module lpmpc_host
    import lpmpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    lpmpc_if.host bus,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_mode,
    input wire logic xact_pending,
    output logic cmd_busy,
    output logic [2:0] dev_state
);
    typedef struct packed {
        logic req_valid;
        logic [1:0] req_mode;
        logic busy;
        logic [2:0] dst;
    } lpmpc_hst_s;
    lpmpc_hst_s s_q, s_d;

    // Hold the request until acknowledged; wait for transactions to drain
    always_comb begin
        s_d = s_q;
        s_d.dst = bus.state;
        if (!s_q.busy && cmd_valid && cmd_mode != `LPMPC_REQ_NONE) begin
            s_d.busy = 1'h1;
            s_d.req_mode = cmd_mode;
        end
        if (s_q.busy && !s_q.req_valid && !xact_pending) begin
            s_d.req_valid = 1'h1;
        end
        if (s_q.req_valid && bus.req_ack) begin
            s_d.req_valid = 1'h0;
            s_d.busy = 1'h0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.req_valid = s_q.req_valid;
    assign bus.req_mode = s_q.req_mode;
    assign cmd_busy = s_q.busy;
    assign dev_state = s_q.dst;
endmodule
`default_nettype wire

// file: src/lpmpc_dev.sv
// Device end: power state sequencer and pad control
// Function
// - PHY-off suspend disables PHY, freezes USB interface
// - PHY-off suspend stops clocks, disables PLLs
// - Pins keep pre-entry level during suspend
// - Suspend retains registers, buffers and RAM
// - Transactions finish before suspend request
// - Non-reset wake resumes with unchanged PC
// - Suspend request from firmware or host mailbox
// - Suspend wakes on lines, role, bus, CTS, ctrl0
// - Standby keeps config and RAM, not buffers
// - Standby wake resets PC, restarts core
// - Standby stops oscillator, PLL, core; GPIO config kept
// - Standby entered by power register write
// - Standby wakes only on bus, CTS, ctrl0
// - Core power-down loses all; reset reloads
// - Pin pull select: hi-Z, pull-up, pull-down
// - Hold keeps pin value in low power
// - Drive strength four levels per interface
// - Unused parallel controls as GPIO, except 15
// - Unused serial pins as GPIO
// - Firmware pulls up unused pins, floats outputs
// - Test port pulls fixed, not firmware settable
// - PHY-on suspend keeps PHY in U3 only
`timescale 1ns/1ps
`default_nettype none
`include "lpmpc_consts.svh"
module lpmpc_dev
    import lpmpc_pkg::*;
#(
    parameter int NPINS = `LPMPC_NPINS,
    parameter int NIFS = `LPMPC_NIFS,
    parameter int LOCK_CYC = `LPMPC_PLL_LOCK_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    lpmpc_if.dev bus,
    input wire logic fw_req_valid,
    input wire logic [1:0] fw_req_mode,
    input wire logic pll_locked,
    input wire logic dp_line,
    input wire logic dm_line,
    input wire logic usb_role_detect_pin,
    input wire logic vbus_detect,
    input wire logic cts_line,
    input wire logic cts_wake_pol,
    input wire logic parallel_ctrl0_wake,
    input wire logic [NPINS-1:0] pin_out_fn,
    input wire logic [NPINS-1:0] pin_oe_fn,
    input wire logic [NPINS-1:0] gpio_sel,
    input wire logic [NPINS-1:0] gpio_out,
    input wire logic [NPINS-1:0] gpio_oe,
    input wire logic [2*NPINS-1:0] pull_cfg,
    input wire logic [2*NIFS-1:0] drive_cfg,
    input wire logic [NPINS-1:0] pin_if_sel,
    output logic osc_en,
    output logic pll_en,
    output logic core_clk_en,
    output logic core_pwr_en,
    output logic core_pc_reset,
    output logic phy_en,
    output logic phy_u3,
    output logic usb_suspend,
    output logic buf_retain,
    output logic [NPINS-1:0] pad_out,
    output logic [NPINS-1:0] pad_oe_n,
    output logic [NPINS-1:0] pad_pull_up,
    output logic [NPINS-1:0] pad_pull_down,
    output logic [2*NPINS-1:0] pad_drive,
    output logic test_pull_up,
    output logic test_clk_pull_down
);
    typedef struct packed {
        lpmpc_state_e st;
        logic [`LPMPC_CNT_W-1:0] cnt;
        logic from_stby;
        logic ack;
        logic dp;
        logic dm;
        logic role;
        logic osc;
        logic pll;
        logic clk;
        logic pwr;
        logic pcr;
        logic phy;
        logic u3;
        logic susp;
        logic bret;
        logic hold;
        logic idle;
        logic tpu;
        logic tpd;
        logic [NPINS-1:0] out;
        logic [NPINS-1:0] oe_n;
        logic [NPINS-1:0] pu;
        logic [NPINS-1:0] pd;
        logic [2*NPINS-1:0] drv;
    } lpmpc_dev_s;
    lpmpc_dev_s s_q, s_d;

    logic req_v;
    lpmpc_req_t req_m;
    logic line_evt;
    logic cts_evt;
    logic lvl_wake;

    // Merge firmware and mailbox requests; host takes priority
    assign req_v = bus.req_valid | fw_req_valid;
    assign req_m = bus.req_valid ? bus.req_mode : fw_req_mode;
    assign line_evt = (dp_line != s_q.dp) | (dm_line != s_q.dm)
        | (usb_role_detect_pin != s_q.role);
    assign cts_evt = (cts_line == cts_wake_pol);
    assign lvl_wake = vbus_detect | cts_evt | parallel_ctrl0_wake;

    // Next state of sequencer and pads
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'h0;
        s_d.dp = dp_line;
        s_d.dm = dm_line;
        s_d.role = usb_role_detect_pin;
        s_d.pcr = 1'h0;
        case (s_q.st)
            LPMPC_RUN: begin
                if (req_v && !s_q.ack && req_m != `LPMPC_REQ_NONE) begin
                    s_d.ack = bus.req_valid;
                    s_d.hold = 1'h1;
                    s_d.clk = 1'h0;
                    s_d.bret = 1'h1;
                    if (req_m == `LPMPC_REQ_PHYON) begin
                        s_d.st = LPMPC_PHYON;
                        s_d.u3 = 1'h1;
                        s_d.susp = 1'h1;
                    end else if (req_m == `LPMPC_REQ_PHYOFF) begin
                        s_d.st = LPMPC_PHYOFF;
                        s_d.phy = 1'h0;
                        s_d.susp = 1'h1;
                        s_d.pll = 1'h0;
                        s_d.osc = 1'h0;
                    end else begin
                        s_d.st = LPMPC_STBY;
                        s_d.bret = 1'h0;
                        s_d.pll = 1'h0;
                        s_d.osc = 1'h0;
                        s_d.pwr = 1'h0;
                    end
                end
            end
            LPMPC_PHYON, LPMPC_PHYOFF: begin
                if (line_evt || lvl_wake) begin
                    s_d.st = LPMPC_LOCK;
                    s_d.from_stby = 1'h0;
                    s_d.osc = 1'h1;
                    s_d.pll = 1'h1;
                    s_d.cnt = '0;
                end
            end
            LPMPC_STBY: begin
                if (lvl_wake) begin
                    s_d.st = LPMPC_LOCK;
                    s_d.from_stby = 1'h1;
                    s_d.osc = 1'h1;
                    s_d.pll = 1'h1;
                    s_d.pwr = 1'h1;
                    s_d.cnt = '0;
                end
            end
            LPMPC_LOCK: begin
                if (s_q.cnt != LOCK_CYC[`LPMPC_CNT_W-1:0]) begin
                    s_d.cnt = s_q.cnt + `LPMPC_CNT_W'(1);
                end else if (pll_locked) begin
                    s_d.st = LPMPC_RUN;
                    s_d.clk = 1'h1;
                    s_d.pcr = s_q.from_stby;
                    s_d.phy = 1'h1;
                    s_d.u3 = 1'h0;
                    s_d.susp = 1'h0;
                    s_d.hold = 1'h0;
                    s_d.bret = 1'h1;
                end
            end
            default: begin
                s_d.st = LPMPC_RUN;
            end
        endcase
        // Idle flag is registered together with the state it reports
        s_d.idle = (s_d.st == LPMPC_RUN);
        // Pad muxing, frozen while hold is set
        if (!s_d.hold) begin
            for (int i = 0; i < NPINS; i++) begin
                if (gpio_sel[i] && i != `LPMPC_CTL15_IDX) begin
                    s_d.out[i] = gpio_out[i];
                    s_d.oe_n[i] = !gpio_oe[i];
                end else begin
                    s_d.out[i] = pin_out_fn[i];
                    s_d.oe_n[i] = !pin_oe_fn[i];
                end
                s_d.pu[i] = pull_cfg[2*i +: 2] == `LPMPC_PULL_UP;
                s_d.pd[i] = pull_cfg[2*i +: 2] == `LPMPC_PULL_DOWN;
                s_d.drv[2*i +: 2] = drive_cfg[2*pin_if_sel[i] +: 2];
            end
        end
    end

    // State register; power-on reset models supply return
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= LPMPC_RUN;
            s_q.osc <= 1'h1;
            s_q.pll <= 1'h1;
            s_q.clk <= 1'h1;
            s_q.pwr <= 1'h1;
            s_q.phy <= 1'h1;
            s_q.bret <= 1'h1;
            s_q.pcr <= 1'h1;
            s_q.idle <= 1'h1;
            s_q.tpu <= 1'h1;
            s_q.tpd <= 1'h1;
            s_q.oe_n <= '1;
            s_q.pu <= '1;
            s_q.drv <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.req_ack = s_q.ack;
    assign bus.idle = s_q.idle;
    assign bus.state = s_q.st;
    assign bus.woke_reset_pc = s_q.pcr;
    assign osc_en = s_q.osc;
    assign pll_en = s_q.pll;
    assign core_clk_en = s_q.clk;
    assign core_pwr_en = s_q.pwr;
    assign core_pc_reset = s_q.pcr;
    assign phy_en = s_q.phy;
    assign phy_u3 = s_q.u3;
    assign usb_suspend = s_q.susp;
    assign buf_retain = s_q.bret;
    assign pad_out = s_q.out;
    assign pad_oe_n = s_q.oe_n;
    assign pad_pull_up = s_q.pu;
    assign pad_pull_down = s_q.pd;
    assign pad_drive = s_q.drv;
    // Fixed test port pulls, set by reset and never written by firmware
    assign test_pull_up = s_q.tpu;
    assign test_clk_pull_down = s_q.tpd;
endmodule
`default_nettype wire

// file: test/lpmpc_assertions.sv
// Checker for the request handshake between host and device ends
`timescale 1ns/1ps
`default_nettype none
module lpmpc_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [1:0] req_mode,
    input wire logic req_ack,
    input wire logic idle,
    input wire logic [2:0] state,
    input wire logic woke_reset_pc
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Request handshake
    property p_ack_pulse; req_ack |=> !req_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        req_ack |-> $past(req_valid) && $past(idle) && $past(req_mode) != 2'h0;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_hold; req_valid && !req_ack |=> req_valid && $stable(req_mode); endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    // ==========================================
    // State entry and exit
    property p_phyoff; req_ack && $past(req_mode) == 2'h2 |-> state == 3'h3; endproperty
    a_phyoff: assert property (p_phyoff) else $error("no phy-off entry");
    property p_phyon; req_ack && $past(req_mode) == 2'h1 |-> state == 3'h1; endproperty
    a_phyon: assert property (p_phyon) else $error("no phy-on entry");
    property p_stby; req_ack && $past(req_mode) == 2'h3 |-> state == 3'h2; endproperty
    a_stby: assert property (p_stby) else $error("no standby entry");
    property p_idle; idle == (state == 3'h0); endproperty
    a_idle: assert property (p_idle) else $error("idle wrong");
    property p_lock; state == 3'h6 |=> state inside {3'h6, 3'h0}; endproperty
    a_lock: assert property (p_lock) else $error("bad lock exit");
    property p_low;
        state inside {3'h1, 3'h2, 3'h3} |=> state == $past(state) || state == 3'h6;
    endproperty
    a_low: assert property (p_low) else $error("wake skipped lock");
    property p_pc; woke_reset_pc && $past(rst_n) |=> !woke_reset_pc; endproperty
    a_pc: assert property (p_pc) else $error("pc reset too long");
endmodule
`default_nettype wire

// file: test/low_power_mode_and_pad_control_bench.sv
// Self-checking bench for both ends of the power sequencer
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_and_pad_control_bench;
    import lpmpc_pkg::*;
    typedef struct {int sel; logic [31:0] e; logic [31:0] m;} lpmpc_note_s;
    logic ref_clk = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, xact = 1'h0, fw_v = 1'h0;
    logic dp = 1'h0, dm = 1'h0, role = 1'h0, vbus = 1'h0, cts = 1'h0, ctl0 = 1'h0, pol = 1'h1;
    logic [2:0] lk = 3'h0;
    logic locked = 1'h0, busy, osc, pll, cke, pwr, pcr, phy, u3, susp, bret, tpu, tpd;
    logic [1:0] cmd_mode = 2'h0, fw_mode = 2'h0;
    logic [15:0] fn_out = 16'h0, fn_oe = 16'hFFFF, gsel = 16'h0, gout = 16'h0, goe = 16'h0;
    logic [15:0] ifsel = 16'h00FF, r = 16'h0012, pout, poe_n, pup, pdn;
    logic [31:0] pull = 32'h0, pdrv;
    logic [31:0] obs [5];
    logic [3:0] drv = 4'h6;
    logic [2:0] dst;
    lpmpc_note_s q [$];
    lpmpc_note_s n;
    event seen;
    int n_mismatch = 0;
    int comparisons = 0;
    lpmpc_if bus ();
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    lpmpc_host i_lpmpc_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_mode(cmd_mode), .xact_pending(xact), .cmd_busy(busy), .dev_state(dst));
    lpmpc_dev #(.LOCK_CYC(2)) i_lpmpc_dev (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
        .fw_req_valid(fw_v), .fw_req_mode(fw_mode), .pll_locked(locked), .dp_line(dp),
        .dm_line(dm), .usb_role_detect_pin(role), .vbus_detect(vbus), .cts_line(cts),
        .cts_wake_pol(pol), .parallel_ctrl0_wake(ctl0), .pin_out_fn(fn_out), .pin_oe_fn(fn_oe),
        .gpio_sel(gsel), .gpio_out(gout), .gpio_oe(goe), .pull_cfg(pull), .drive_cfg(drv),
        .pin_if_sel(ifsel), .osc_en(osc), .pll_en(pll), .core_clk_en(cke), .core_pwr_en(pwr),
        .core_pc_reset(pcr), .phy_en(phy), .phy_u3(u3), .usb_suspend(susp), .buf_retain(bret),
        .pad_out(pout), .pad_oe_n(poe_n), .pad_pull_up(pup), .pad_pull_down(pdn),
        .pad_drive(pdrv), .test_pull_up(tpu), .test_clk_pull_down(tpd));
    lpmpc_assertions i_lpmpc_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
        .req_valid(bus.req_valid), .req_mode(bus.req_mode), .req_ack(bus.req_ack),
        .idle(bus.idle), .state(bus.state), .woke_reset_pc(bus.woke_reset_pc));
    // PLL model locks four cycles after enable, later than the sim lock counter
    always @(posedge ref_clk) {locked, lk} <= {lk, pll};
    // Observed outputs grouped for the monitor
    always_comb begin
        obs[0] = {23'h0, osc, pll, cke, pwr, pcr, phy, u3, susp, bret};
        obs[1] = {16'h0, pout};
        obs[2] = {pup, pdn};
        obs[3] = pdrv;
        obs[4] = {10'h0, busy, dst, tpu, tpd, poe_n};
    end
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(logic [31:0] got, logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic note(int sel, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF);
        q.push_back('{sel, e & m, m});
        ->seen;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // Bounded wait on the core clock enable, then its value is noted
    task automatic wait_cke(logic v);
        for (int i = 0; i < 60 && cke !== v; i++) tick(1);
        note(0, {23'h0, v, 6'h0}, 32'h40);
    endtask
    task automatic send(logic [1:0] m);
        @(posedge ref_clk);
        cmd_valid <= 1'h1;
        cmd_mode <= m;
        @(posedge ref_clk);
        cmd_valid <= 1'h0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Monitor takes the oldest notes whenever results are flagged
    initial begin
        forever begin
            @(seen);
            while (q.size() > 0) begin
                n = q.pop_front();
                check(obs[n.sel] & n.m, n.e);
            end
        end
    end
    // Watchdog cuts a hang short
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        tick(2);
        note(4, 32'h30000);
        r = lfsr(r);
        @(posedge ref_clk);
        fn_out <= r;
        gsel <= 16'hFFFF;
        gout <= ~r;
        tick(2);
        note(1, {16'h0, r[15], ~r[14:0]});
        for (int c = 0; c < 4; c++) begin
            @(posedge ref_clk);
            pull <= {16{c[1:0]}};
            tick(2);
            note(2, {(c == 1) ? 16'hFFFF : 16'h0, (c == 2) ? 16'hFFFF : 16'h0});
        end
        note(3, 32'hAAAA5555);
        @(posedge ref_clk);
        gsel <= 16'h0;
        xact <= 1'h1;
        send(2'h2);
        tick(5);
        note(0, 32'h1E9);
        note(4, 32'h200000, 32'h3C0000);
        @(posedge ref_clk);
        xact <= 1'h0;
        wait_cke(1'h0);
        note(0, 32'h023);
        @(posedge ref_clk);
        fn_out <= ~r;
        tick(3);
        note(1, {16'h0, r});
        note(4, 32'h0C0000, 32'h3C0000);
        @(posedge ref_clk);
        dp <= 1'h1;
        tick(5);
        note(0, 32'h0, 32'h40);
        wait_cke(1'h1);
        note(0, 32'h1E8, 32'h1F8);
        tick(1);
        note(1, {16'h0, ~r});
        send(2'h1);
        wait_cke(1'h0);
        note(0, 32'h0C, 32'h4C);
        @(posedge ref_clk);
        cts <= 1'h1;
        wait_cke(1'h1);
        note(0, 32'h1E8, 32'h1F8);
        @(posedge ref_clk);
        cts <= 1'h0;
        fw_v <= 1'h1;
        fw_mode <= 2'h3;
        wait_cke(1'h0);
        note(0, 32'h0, 32'h1E1);
        @(posedge ref_clk);
        fw_v <= 1'h0;
        dp <= 1'h0;
        dm <= 1'h1;
        role <= 1'h1;
        tick(6);
        note(0, 32'h0, 32'h1E0);
        @(posedge ref_clk);
        ctl0 <= 1'h1;
        wait_cke(1'h1);
        note(0, 32'h1F8, 32'h1F8);
        @(posedge ref_clk);
        ctl0 <= 1'h0;
        pol <= 1'h0;
        cts <= 1'h1;
        send(2'h3);
        wait_cke(1'h0);
        note(0, 32'h0, 32'h1E1);
        @(posedge ref_clk);
        cts <= 1'h0;
        wait_cke(1'h1);
        note(0, 32'h1F8, 32'h1F8);
        @(posedge ref_clk);
        pol <= 1'h1;
        fw_v <= 1'h1;
        fw_mode <= 2'h2;
        wait_cke(1'h0);
        note(0, 32'h023);
        @(posedge ref_clk);
        fw_v <= 1'h0;
        vbus <= 1'h1;
        wait_cke(1'h1);
        note(0, 32'h1E8, 32'h1F8);
        tick(2);
        report_and_stop();
    end
endmodule
`default_nettype wire
